// [hw/asb_pkg.sv]
package asb_pkg;

   // Buffer operating modes as held in the two-bit mode field.
   typedef enum logic [1:0]
   {
      ASB_FIFO    = 2'h0,
      ASB_STREAM  = 2'h1,
      ASB_TRIGGER = 2'h2,
      ASB_OFF     = 2'h3
   } asb_mode_t;

   typedef logic [7:0] asb_byte_t;
   typedef logic [9:0] asb_idx_t;

endpackage

// [hw/asb_regs.svh]
`ifndef ASB_REGS_SVH
`define ASB_REGS_SVH

// Register offsets on the byte-wide register port.
`define ASB_OFF_THRESHOLD 8'h5e
`define ASB_OFF_CONTROL   8'h5f
`define ASB_OFF_LEVEL_LO  8'h60
`define ASB_OFF_LEVEL_HI  8'h61
`define ASB_OFF_FLUSH     8'h62
`define ASB_OFF_OUTPUT    8'h63

// Reset values of the writable registers.
`define ASB_THRESHOLD_RESET 8'h00
`define ASB_CONTROL_RESET   8'h00

// Field positions in the control and capture registers.
`define ASB_CTL_ACTIVE_BIT 7
`define ASB_CTL_WIDTH_BIT  6
`define ASB_CTL_FULLIE_BIT 5
`define ASB_CTL_MODE_HI    1
`define ASB_CTL_MODE_LO    0
`define ASB_CAPTURE_BIT    7

// Ring size and usable capacity in bytes for each sample width.
`define ASB_RING_BYTES 11'h204
`define ASB_CAP16      11'h204
`define ASB_CAP8       11'h201

// Bytes in one three-axis sample set.
`define ASB_SET16 11'h006
`define ASB_SET8  11'h003

// Longest delay of the level status after a read.
`define ASB_CLK_PERIOD_PS  1000 * 4
`define ASB_LEVEL_DELAY_NS 1000
`define ASB_LEVEL_DELAY_CYC ((`ASB_LEVEL_DELAY_NS * 1000) / (`ASB_CLK_PERIOD_PS))

`endif

// [hw/asb_top.sv]
// Overview of operation
// (R01) FIFO and Stream: threshold counts sample sets that raise the watermark.
// (R02) Trigger: threshold is the count of pre-trigger sets kept.
// (R03) Host programs threshold 2..86 at 16-bit, 2..171 at 8-bit.
// (R04) Threshold, control and flush registers take writes while running, no disruption.
// (R05) Active bit enables the buffer; writing it zero empties the buffer.
// (R06) Dropping the operating enable to standby empties the buffer.
// (R07) Width bit selects 8-bit samples at 0, 16-bit at 1.
// (R08) Full flag is raised only while the full interrupt enable is set.
// (R09) Mode field: 00 FIFO, 01 Stream, 10 Trigger.
// (R10) FIFO fills to 171 or 86 sets, stops, resumes when space frees.
// (R11) Stream keeps newest sets; when full the oldest set is dropped.
// (R12) Trigger keeps threshold earlier sets, fills to full, then stops until cleared; the code resumes storing after the trigger once reads free space.
// (R13) Level status follows a read within one microsecond.
// (R14) Level counts bytes: six per set at 16-bit, three at 8-bit.
// (R15) Capture flag reports trigger; event is OR of six motion sources.
// (R16) Any write to the flush register empties buffer and zeroes the level.
// (R17) In Trigger mode a flush write also clears the capture flag; a trigger event in the same cycle leaves it set.
// (R18) A flush write clears full and watermark flags and releases the pin.
// (R19) Host reads single bytes or whole sets of six or three bytes.
// (R20) Host finishes a burst within one output data period.
// (R21) Output port gives two's complement bytes while filling continues.
// (R22) Raw data is stored by default; a select bit picks the advanced path.
// (R23) Each output read removes the oldest byte; an empty buffer reads zero.
// (R24) Watermark latches when stored sets reach the threshold, until cleared.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "asb_regs.svh"

module asb_top
(
   // Clock and reset.
   input  wire logic             CLK,
   input  wire logic             RST_N,
   // Register port.
   input  wire logic [7:0]       ADDR,
   input  wire logic [7:0]       WDATA,
   input  wire logic             WR_STB,
   input  wire logic             RD_STB,
   output logic      [7:0]       RDATA,
   // Sensor configuration.
   input  wire logic             OPERATING_ENABLE,
   input  wire logic             BUFFER_SOURCE_SELECT,
   // Sample sources.
   input  wire logic             SAMPLE_VALID,
   input  wire logic [15:0]      RAW_X,
   input  wire logic [15:0]      RAW_Y,
   input  wire logic [15:0]      RAW_Z,
   input  wire logic [15:0]      ADP_X,
   input  wire logic [15:0]      ADP_Y,
   input  wire logic [15:0]      ADP_Z,
   // Trigger sources.
   input  wire logic             FREEFALL_FLAG,
   input  wire logic             IMPACT_STATUS_HI,
   input  wire logic             IMPACT_STATUS_LO,
   input  wire logic             MOTION_WAKE_FLAG,
   input  wire logic             TILT_CHANGE_FLAG,
   input  wire logic             EXTERNAL_CAPTURE_EVENT,
   // Status toward the interrupt controller.
   output logic                  WATERMARK_FLAG,
   output logic                  FULL_IRQ_FLAG,
   output logic                  CAPTURE_FLAG,
   output logic                  FLUSH_PULSE
);
   import asb_pkg::*;

   // All state of the block.
   typedef struct packed
   {
      logic [`ASB_RING_BYTES-1:0][7:0] mem;
      asb_idx_t                        rptr;
      asb_idx_t                        wptr;
      asb_idx_t                        level;
      logic [5:0][7:0]                 pend;
      logic [2:0]                      cnt;
      asb_byte_t                       thr;
      logic                            active;
      logic                            width16;
      logic                            full_ie;
      asb_mode_t                       mode;
      logic                            capture;
      logic                            wm;
      logic                            full;
      logic                            flush_p;
      asb_byte_t                       rdata;
   } asb_state_t;

   asb_state_t  s_q;
   asb_state_t  s_d;

   logic        flush_wr;
   logic        flush_req;
   logic        pop;
   logic        accept;
   logic        drop;
   logic        external_capture_event_evt;
   logic        pre_external_capture_event;
   logic [10:0] set11;
   logic [10:0] cap11;
   logic [10:0] thb11;
   logic [10:0] limit11;
   logic [10:0] lv1;
   asb_idx_t    rp1;
   logic [15:0] src_x;
   logic [15:0] src_y;
   logic [15:0] src_z;

   // Advances a ring index by n bytes, wrapping at the ring size.
   function automatic asb_idx_t ring_add(input asb_idx_t p, input logic [10:0] n);
      logic [10:0] t;
      t = {1'b0, p} + n;
      if (t >= `ASB_RING_BYTES)
      begin
         t = t - `ASB_RING_BYTES;
      end
      return t[9:0];
   endfunction

   // Source and size decisions that several parts of the logic share.
   always_comb
   begin
      src_x    = BUFFER_SOURCE_SELECT ? ADP_X : RAW_X;                       // see (R22)
      src_y    = BUFFER_SOURCE_SELECT ? ADP_Y : RAW_Y;
      src_z    = BUFFER_SOURCE_SELECT ? ADP_Z : RAW_Z;
      set11    = s_q.width16 ? `ASB_SET16 : `ASB_SET8;                       // see (R14)
      cap11    = s_q.width16 ? `ASB_CAP16 : `ASB_CAP8;                       // see (R10)
      thb11    = {3'h0, s_q.thr} * set11;                                    // see (R01)
      external_capture_event_evt = FREEFALL_FLAG | IMPACT_STATUS_HI | IMPACT_STATUS_LO         // see (R15)
               | MOTION_WAKE_FLAG | TILT_CHANGE_FLAG | EXTERNAL_CAPTURE_EVENT;
      pre_external_capture_event = (s_q.mode == ASB_TRIGGER) && !s_q.capture;                  // see (R02)
      limit11  = (pre_external_capture_event && (thb11 < cap11)) ? thb11 : cap11;
   end

   // Flush sources, read pop and the acceptance of a new sample set.
   always_comb
   begin
      flush_wr  = WR_STB && (ADDR == `ASB_OFF_FLUSH);                        // see (R16)
      flush_req = flush_wr || !s_q.active || !OPERATING_ENABLE;              // see (R05) (R06)
      pop       = RD_STB && (ADDR == `ASB_OFF_OUTPUT) && (s_q.level != '0)   // see (R23)
                  && !flush_req;
      lv1       = {1'b0, s_q.level} - {10'h0, pop};
      rp1       = pop ? ring_add(s_q.rptr, 11'h001) : s_q.rptr;
      accept    = 1'b0;
      drop      = 1'b0;
      if (SAMPLE_VALID && (s_q.cnt == '0) && !flush_req && (s_q.mode != ASB_OFF))
      begin
         if ((lv1 + set11) <= limit11)
         begin
            accept = 1'b1;                                                   // see (R10)
         end
         else if (((s_q.mode == ASB_STREAM) || pre_external_capture_event) && (lv1 >= set11))
         begin
            accept = 1'b1;                                                   // see (R11)
            drop   = 1'b1;
         end
      end
   end

   // Next state: register writes, byte writer, level and flags.
   always_comb
   begin
      s_d         = s_q;
      s_d.flush_p = flush_wr;                                                // see (R18)
      s_d.rdata   = '0;
      // Live register writes take effect on the next edge.
      if (WR_STB && (ADDR == `ASB_OFF_THRESHOLD))
      begin
         s_d.thr = WDATA;                                                    // see (R04)
      end
      if (WR_STB && (ADDR == `ASB_OFF_CONTROL))
      begin
         s_d.active  = WDATA[`ASB_CTL_ACTIVE_BIT];                           // see (R05)
         s_d.width16 = WDATA[`ASB_CTL_WIDTH_BIT];                            // see (R07)
         s_d.full_ie = WDATA[`ASB_CTL_FULLIE_BIT];
         s_d.mode    = asb_mode_t'(WDATA[`ASB_CTL_MODE_HI:`ASB_CTL_MODE_LO]); // see (R09)
      end
      // Read data appears only in the cycle after the strobe.
      if (RD_STB)
      begin
         case (ADDR)
            `ASB_OFF_THRESHOLD: s_d.rdata = s_q.thr;
            `ASB_OFF_CONTROL:   s_d.rdata = {s_q.active, s_q.width16, s_q.full_ie,
                                             3'h0, s_q.mode};
            `ASB_OFF_LEVEL_LO:  s_d.rdata = s_q.level[7:0];
            `ASB_OFF_LEVEL_HI:  s_d.rdata = {s_q.capture, 5'h00, s_q.level[9:8]};
            `ASB_OFF_OUTPUT:    s_d.rdata = pop ? s_q.mem[s_q.rptr] : 8'h00; // see (R21) (R23)
            default:            s_d.rdata = 8'h00;
         endcase
      end
      // Pointers and level: pop first, then drop, then one byte written.
      s_d.rptr  = drop ? ring_add(rp1, set11) : rp1;                         // see (R11)
      s_d.level = lv1[9:0] - (drop ? set11[9:0] : 10'h000);
      if (s_q.cnt != '0)
      begin
         s_d.mem[s_q.wptr] = s_q.pend[0];
         s_d.pend          = {8'h00, s_q.pend[5:1]};
         s_d.cnt           = s_q.cnt - 3'h1;
         s_d.wptr          = ring_add(s_q.wptr, 11'h001);
         s_d.level         = s_d.level + 10'h001;                            // see (R14)
      end
      // A taken set is queued axis by axis, low byte first at 16-bit and high bytes only at 8-bit.
      if (accept)
      begin
         if (s_q.width16)
         begin
            s_d.pend = {src_z[15:8], src_z[7:0], src_y[15:8], src_y[7:0],
                        src_x[15:8], src_x[7:0]};
            s_d.cnt  = 3'h6;
         end
         else
         begin
            s_d.pend = {8'h00, 8'h00, 8'h00, src_z[15:8], src_y[15:8], src_x[15:8]};
            s_d.cnt  = 3'h3;
         end
      end
      // Any flush source empties the ring and aborts a queued set.
      if (flush_req)
      begin
         s_d.rptr  = '0;                                                     // see (R16)
         s_d.wptr  = '0;
         s_d.level = '0;
         s_d.cnt   = '0;
         s_d.wm    = 1'b0;                                                   // see (R18)
         s_d.full  = 1'b0;
      end
      if ((flush_wr && (s_q.mode == ASB_TRIGGER)) || !s_q.active || !OPERATING_ENABLE)
      begin
         s_d.capture = 1'b0;                                                 // see (R17)
      end
      // The capture set comes last so a trigger event beats a flush-write clear in the same cycle.
      if ((s_q.mode == ASB_TRIGGER) && external_capture_event_evt && s_q.active && OPERATING_ENABLE)
      begin
         s_d.capture = 1'b1;                                                 // see (R12) (R15)
      end
      // Watermark and full describe the stored contents, which a flush empties.
      // Raising them in the flush cycle would latch them for good, so the flush
      // keeps them down; this also keeps them low while the buffer is inactive.
      if (((s_q.mode == ASB_FIFO) || (s_q.mode == ASB_STREAM))
          && ({1'b0, s_q.level} >= thb11) && !flush_req)
      begin
         s_d.wm = 1'b1;                                                      // see (R24) (R01)
      end
      if (s_q.full_ie && (s_q.cnt == '0) && (({1'b0, s_q.level} + set11) > cap11)
          && !flush_req)
      begin
         s_d.full = 1'b1;                                                    // see (R08)
      end
   end

   // State register; every field clears at reset.
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register.
   assign RDATA          = s_q.rdata;
   assign WATERMARK_FLAG = s_q.wm;
   assign FULL_IRQ_FLAG  = s_q.full;
   assign CAPTURE_FLAG   = s_q.capture;
   assign FLUSH_PULSE    = s_q.flush_p;

   // Checks on the buffer behaviour.
   localparam int LVL_WAIT = `ASB_LEVEL_DELAY_CYC;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   sequence seq_take16;
      accept && s_q.width16 && !flush_req;
   endsequence

   sequence seq_take8;
      accept && !s_q.width16 && !flush_req;
   endsequence

   sequence seq_external_capture_event_full;
      (s_q.mode == ASB_TRIGGER) && s_q.capture && (s_q.cnt == '0)
      && (({1'b0, s_q.level} + set11) > cap11) && SAMPLE_VALID;
   endsequence

   chk_flush_empties: assert property (flush_wr |=> (s_q.level == '0) && (s_q.cnt == '0)) // see (R16)
      else $error("flush write did not empty the buffer");

   chk_standby_empty: assert property (!OPERATING_ENABLE |=> (s_q.level == '0))           // see (R06)
      else $error("standby did not empty the buffer");

   chk_inactive_empty: assert property (!s_q.active |=> (s_q.level == '0))                // see (R05)
      else $error("inactive buffer holds data");

   chk_set_bytes_16: assert property (seq_take16 |=> (s_q.cnt == 3'h6) ##6 (s_q.cnt == '0)) // see (R14)
      else $error("16-bit set did not queue six bytes");

   chk_set_bytes_8: assert property (seq_take8 |=> (s_q.cnt == 3'h3) ##3 (s_q.cnt == '0))  // see (R14)
      else $error("8-bit set did not queue three bytes");

   chk_fifo_stops_full: assert property (((s_q.mode == ASB_FIFO) && SAMPLE_VALID            // see (R10)
         && (s_q.cnt == '0) && ((lv1 + set11) > cap11)) |-> !accept)
      else $error("FIFO took a set while full");

   chk_stream_drops_oldest: assert property ((drop && !pop && !flush_req) |=>               // see (R11)
         (s_q.level == $past(s_q.level) - $past(set11[9:0])))
      else $error("stream did not drop one set");

   chk_external_capture_event_stops_full: assert property (seq_external_capture_event_full |-> !accept)                       // see (R12)
      else $error("trigger mode stored past full");

   chk_capture_cleared: assert property ((flush_wr && (s_q.mode == ASB_TRIGGER)           // see (R17)
         && !external_capture_event_evt) |=> !s_q.capture)
      else $error("flush in trigger mode kept capture flag");

   chk_flags_cleared: assert property (flush_wr                                           // see (R18)
         |=> !s_q.full && !s_q.wm && s_q.flush_p)
      else $error("flush write left a flag set");

   chk_watermark_latch: assert property ((((s_q.mode == ASB_FIFO) || (s_q.mode == ASB_STREAM)) // see (R24)
         && ({1'b0, s_q.level} >= thb11) && !flush_req) |=> s_q.wm [*2] or flush_req)
      else $error("watermark not latched at threshold");

   chk_full_gated: assert property ($rose(s_q.full) |-> $past(s_q.full_ie))                // see (R08)
      else $error("full flag raised while disabled");

   chk_empty_reads_zero: assert property ((RD_STB && (ADDR == `ASB_OFF_OUTPUT)             // see (R23)
         && (s_q.level == '0)) |=> (RDATA == 8'h00))
      else $error("empty buffer read returned data");

   chk_level_follows: assert property ((pop && (s_q.cnt == '0) && !drop) |->                 // see (R13)
         ##[1:LVL_WAIT] (s_q.level != $past(s_q.level)))
      else $error("level did not follow a read in time");

   // Checks on the flags, the read data and the sample path.
   chk_pop_level: assert property ((pop && (s_q.cnt == '0) && !drop)                       // see (R23)
         |=> (s_q.level == $past(s_q.level) - 10'h001))
      else $error("read did not remove exactly one byte");

   chk_capture_sets: assert property (((s_q.mode == ASB_TRIGGER) && external_capture_event_evt && s_q.active // see (R15)
         && OPERATING_ENABLE) |=> s_q.capture)
      else $error("trigger event did not set the capture flag");

   chk_flush_pulse: assert property (s_q.flush_p == $past(flush_wr))                       // see (R18)
      else $error("flush pulse does not follow the flush write");

   chk_rdata_idle: assert property (!RD_STB |=> (RDATA == 8'h00))                          // see (R21)
      else $error("read data stood without a read strobe");

   chk_wm_mode: assert property ($rose(s_q.wm)                                             // see (R01)
         |-> $past((s_q.mode == ASB_FIFO) || (s_q.mode == ASB_STREAM)))
      else $error("watermark raised outside FIFO or Stream mode");

   chk_pretrig_keep: assert property ((pre_external_capture_event && accept && !drop)                        // see (R02)
         |-> ((lv1 + set11) <= thb11))
      else $error("pre-trigger buffer kept more than the threshold");

   chk_width_high: assert property ((accept && !s_q.width16)                               // see (R07)
         |=> (s_q.pend[0] == $past(src_x[15:8])))
      else $error("8-bit set did not queue the high byte first");

   chk_source_path: assert property ((accept && s_q.width16)                               // see (R22)
         |=> (s_q.pend[0] == $past(BUFFER_SOURCE_SELECT ? ADP_X[7:0] : RAW_X[7:0])))
      else $error("stored set came from the wrong source");

   chk_off_idle: assert property ((s_q.mode == ASB_OFF) |-> !accept)                       // see (R09)
      else $error("reserved mode stored a set");

   chk_fifo_no_drop: assert property ((s_q.mode == ASB_FIFO) |-> !drop)                    // see (R10)
      else $error("FIFO mode dropped stored data");

endmodule

// [verif/asb_host.sv]
`timescale 1ns/1ps

module asb_host
(
   // Clock.
   input  wire logic       clk,
   // Register port toward the buffer.
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            wr_stb,
   output logic            rd_stb,
   input  wire logic [7:0] rdata
);

   // Idle bus at time zero.
   initial
   begin
      addr   = 8'h00;
      wdata  = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end

   // One-cycle write; the data lines are scrambled once released.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      wdata  <= ~d;
   endtask

   // Single-byte read, done long before the next data period starts.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      d = rdata;
   endtask

endmodule

// [verif/asb_top_test.sv]
`timescale 1ns/1ps
`include "asb_regs.svh"

module asb_top_test;
   import asb_pkg::*;

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr, wdata, rdata, rv, r60, r61;
   logic        wr_stb, rd_stb, wm, full, capt, flp;
   logic        op_en = 1'b1;
   logic        src = 1'b0;
   logic        smp_v = 1'b0;
   logic [47:0] raw = '0;
   logic [5:0]  trg = '0;
   logic [7:0]  q[$];
   logic [1:0]  m = 2'h0;
   logic        w16 = 1'b0;
   logic        external_capture_event = 1'b0;
   int          thr, miscompares, checks_done, flush_cnt, cyc, seed;
   logic [7:0]  offs[7] = '{8'h5e, 8'h5f, 8'h60, 8'h61, 8'h62, 8'h63, 8'h10};

   asb_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
                  .rd_stb(rd_stb), .rdata(rdata));

   asb_top DUT (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
      .RD_STB(rd_stb), .RDATA(rdata), .OPERATING_ENABLE(op_en), .BUFFER_SOURCE_SELECT(src),
      .SAMPLE_VALID(smp_v), .RAW_X(raw[15:0]), .RAW_Y(raw[31:16]), .RAW_Z(raw[47:32]),
      .ADP_X(~raw[15:0]), .ADP_Y(~raw[31:16]), .ADP_Z(~raw[47:32]), .FREEFALL_FLAG(trg[0]),
      .IMPACT_STATUS_HI(trg[1]), .IMPACT_STATUS_LO(trg[2]), .MOTION_WAKE_FLAG(trg[3]),
      .TILT_CHANGE_FLAG(trg[4]), .EXTERNAL_CAPTURE_EVENT(trg[5]), .WATERMARK_FLAG(wm),
      .FULL_IRQ_FLAG(full), .CAPTURE_FLAG(capt), .FLUSH_PULSE(flp));

   // Clock at 4 ns, flush pulse counter and hang guard.
   initial
   begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (flp === 1'b1)
         flush_cnt <= flush_cnt + 1;
      if (cyc == 20000)
      begin
         miscompares++;
         close_out();
      end
   end

   // Byte i of a set {z,y,x}: low/high pairs at 16-bit, high bytes only at 8-bit.
   function automatic logic [7:0] set_byte(logic w, logic [47:0] s, int i);
      if (w)
         return s[8*i +: 8];
      return s[16*i+8 +: 8];
   endfunction

   task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One sample set, then the expected ring contents are updated.
   task automatic push();
      logic [47:0] s;
      int          n, cap;
      s = {16'($urandom), 32'($urandom)};
      @(posedge clk);
      smp_v <= 1'b1;
      raw   <= s;
      @(posedge clk);
      smp_v <= 1'b0;
      repeat (7) @(posedge clk);
      #1;
      if (src)
         s = ~s;
      n = w16 ? 6 : 3;
      cap = (m == ASB_TRIGGER && !external_capture_event) ? thr * n : (w16 ? 516 : 513);
      if (m != ASB_OFF)
      begin
         if (q.size() + n > cap && (m == ASB_STREAM || (m == ASB_TRIGGER && !external_capture_event)))
            repeat (n) void'(q.pop_front());
         if (q.size() + n <= cap)
            for (int i = 0; i < n; i++)
               q.push_back(set_byte(w16, s, i));
      end
   endtask

   task automatic cfg(logic [7:0] c);
      host.wr(`ASB_OFF_CONTROL, c);
      m = c[1:0];
      w16 = c[6];
      if (!c[7])
      begin
         q.delete();
         external_capture_event = 1'b0;
      end
   endtask

   task automatic flush();
      host.wr(`ASB_OFF_FLUSH, 8'($urandom));
      // Let the flush edge settle and the pulse be counted before anything is compared.
      @(posedge clk);
      #1;
      q.delete();
      external_capture_event = 1'b0;
   endtask

   task automatic chk_level();
      host.rd(`ASB_OFF_LEVEL_LO, r60);
      host.rd(`ASB_OFF_LEVEL_HI, r61);
      cmp("level", 16'(q.size()), {6'h00, r61[1:0], r60});
      cmp("capture bit", 16'(external_capture_event), 16'(r61[7]));
   endtask

   task automatic pop(int k);
      repeat (k)
      begin
         host.rd(`ASB_OFF_OUTPUT, rv);
         cmp("output byte", (q.size() > 0) ? 16'(q.pop_front()) : 16'h0, 16'(rv));
      end
   endtask

   task automatic close_out();
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      seed = $urandom(32'h249c3367);
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      foreach (offs[i])
      begin
         host.rd(offs[i], rv);
         cmp("reset read", 16'h0, 16'(rv));
      end
      host.wr(`ASB_OFF_LEVEL_LO, 8'h5a);
      chk_level();
      thr = 3;
      host.wr(`ASB_OFF_THRESHOLD, 8'(thr));
      cfg(8'hc1);
      host.rd(`ASB_OFF_CONTROL, rv);
      cmp("control", 16'hc1, 16'(rv));
      push();
      push();
      cmp("watermark early", 16'h0, 16'(wm));
      push();
      cmp("watermark", 16'h1, 16'(wm));
      chk_level();
      pop(6);
      chk_level();
      flush();
      cmp("watermark cleared", 16'h0, 16'(wm));
      cmp("flush pulses", 16'h1, 16'(flush_cnt));
      chk_level();
      thr = 2;
      host.wr(`ASB_OFF_THRESHOLD, 8'(thr));
      cfg(8'ha0);
      repeat (172) push();
      chk_level();
      cmp("full flag", 16'h1, 16'(full));
      cmp("watermark fifo", 16'h1, 16'(wm));
      pop(3);
      push();
      chk_level();
      flush();
      cmp("full cleared", 16'h0, 16'(full));
      cfg(8'hc1);
      repeat (90) push();
      chk_level();
      cmp("full disabled", 16'h0, 16'(full));
      pop(6);
      cfg(8'hc2);
      for (int k = 0; k < 6; k++)
      begin
         flush();
         repeat (3) push();
         chk_level();
         @(posedge clk);
         trg <= 6'h01 << k;
         @(posedge clk);
         trg <= 6'h00;
         repeat (2) @(posedge clk);
         #1;
         external_capture_event = 1'b1;
         cmp("capture flag", 16'h1, 16'(capt));
         push();
         chk_level();
      end
      repeat (86) push();
      chk_level();
      flush();
      cmp("capture cleared", 16'h0, 16'(capt));
      cfg(8'hc1);
      src <= 1'b1;
      push();
      pop(6);
      @(posedge clk);
      src <= 1'b0;
      cfg(8'hc3);
      push();
      chk_level();
      cfg(8'hc1);
      push();
      push();
      cfg(8'h41);
      chk_level();
      cfg(8'hc1);
      push();
      @(posedge clk);
      op_en <= 1'b0;
      repeat (3) @(posedge clk);
      q.delete();
      external_capture_event = 1'b0;
      chk_level();
      @(posedge clk);
      op_en <= 1'b1;
      close_out();
   end

endmodule
